// >>> src/waveform_engine.sv
// microcoded waveform engine mastering a parallel peripheral, with wishbone registers
`timescale 1ns/100ps
`include "wfe_regs.svh"
module waveform_engine
   import wfe_pkg::*;
(
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic clock_enable_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic interface_clock_in,
   output logic interface_clock_out,
   output logic interface_clock_oe_out,
   output logic [8:0] peripheral_address_out,
   input wire logic [15:0] parallel_data_bus_in,
   output logic [15:0] parallel_data_bus_out,
   output logic [1:0] parallel_data_bus_oe_out,
   output logic [5:0] control_strobe_out,
   input wire logic [5:0] ready_in,
   output logic [2:0] state_debug_out,
   input wire logic host_out_valid_in,
   input wire logic [7:0] host_out_data_in,
   input wire logic host_out_last_in,
   output logic host_out_ready_out,
   output logic host_in_valid_out,
   output logic [7:0] host_in_data_out,
   output logic host_in_last_out,
   input wire logic host_in_take_in
);
   engine_state_s s_r, s_nxt;
   logic [31:0] ucode_r [0:`UC_WORDS-1]; // descriptor RAM, 8 words per type
   logic [31:0] uw; // word of the state now executing
   logic req, wr, uc_hit, tick, wrap, cond, stall, wide;
   logic [5:0] idx;
   logic [31:0] wmask, merged;
   logic [9:0] acc_sum, acc_inc;
   logic [6:0] rdy_ext;
   logic [2:0] nst;
   logic is_fw, is_fr, buf_ok;
   // buffer links
   logic ob_valid, ob_one_left, ob_take, ob_two, ib_ready, ib_push, ib_last;
   logic [15:0] ob_data, ib_rd_data;
   logic [2:0] ob_count, ib_count;
   logic commit_out, commit_in;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode: one request per handshake, answered next edge
   assign req = wb_cyc_in && wb_stb_in && !s_r.ack;
   assign wr = req && wb_we_in;
   assign idx = wb_adr_in[7:2];
   assign uc_hit = wb_adr_in[7];
   assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   assign wide = s_r.cfg[`CFG_WIDE16];
   // manual commit strobes only matter when auto commit is off
   assign commit_out = wr && !uc_hit && idx == `REG_COMMIT && wb_dat_in[0];
   assign commit_in = wr && !uc_hit && idx == `REG_COMMIT && wb_dat_in[1];

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from state
   assign wb_dat_out = s_r.rdat;
   assign wb_ack_out = s_r.ack;
   assign interface_clock_out = s_r.ifc_out;
   assign interface_clock_oe_out = s_r.cfg[`CFG_CLK_OUT];
   assign peripheral_address_out = s_r.addr;
   assign parallel_data_bus_out = s_r.dout;
   assign parallel_data_bus_oe_out = s_r.oe;
   assign control_strobe_out = s_r.ctl;
   assign state_debug_out = s_r.st;

   ////////////////////////////////////////////////////////////////////////////
   // microcode word fetch and qualifier selection
   assign uw = ucode_r[{s_r.typ, s_r.st}];
   assign is_fw = (s_r.typ == FIFO_WRITE);
   assign is_fr = (s_r.typ == FIFO_READ);
   // ready index six reports buffer availability for the fifo kinds
   assign buf_ok = is_fw ? ob_valid : (is_fr ? ib_ready : 1'b1);
   assign rdy_ext = {buf_ok, s_r.rdy_s2};
   assign cond = ((uw[`UC_RSEL_LSB +: 3] == `READY_ALWAYS) ? 1'b1
                  : rdy_ext[uw[`UC_RSEL_LSB +: 3]]) ^ uw[`UC_RPOL];
   // a fifo step waits while its buffer cannot serve, rather than losing data
   assign stall = (uw[`UC_WAIT] && !cond) || (is_fw && uw[`UC_NEXT] && !ob_valid)
                  || (is_fr && uw[`UC_SAMPLE] && !ib_ready);
   assign nst = (uw[`UC_BRANCH] && cond) ? uw[`UC_TGT_T_LSB +: 3] : uw[`UC_TGT_F_LSB +: 3];
   // buffer strobes fire only on an advancing engine step
   assign ob_take = tick && s_r.mode == ENG_RUN && !stall && is_fw && uw[`UC_NEXT];
   assign ob_two = wide && !ob_one_left;
   assign ib_push = tick && s_r.mode == ENG_RUN && !stall && is_fr && uw[`UC_SAMPLE];
   assign ib_last = nst == `IDLE_STATE;

   ////////////////////////////////////////////////////////////////////////////
   // interface clock: fractional divider for the driven clock, edge detect otherwise
   // the phase accumulator adds twice the target rate per reference cycle, so the
   // average rate is exact at the cost of a little period jitter
   assign acc_inc = s_r.cfg[`CFG_CLK_FAST] ? 10'(2 * `IFC_FAST_MHZ) : 10'(2 * `IFC_SLOW_MHZ);
   assign acc_sum = {1'b0, s_r.acc} + acc_inc;
   assign wrap = acc_sum >= 10'(`REF_MHZ);
   // every engine action waits for a rising interface clock edge
   assign tick = s_r.cfg[`CFG_CLK_OUT] ? (wrap && !s_r.ifc_out)
                 : (s_r.ifc_sync[1] && !s_r.ifc_prev);

   ////////////////////////////////////////////////////////////////////////////
   // next state of the whole block
   always_comb begin
      s_nxt = s_r;
      merged = 32'h0000_0000;
      // pin synchronisers: second stage alone feeds logic
      s_nxt.ifc_sync = {s_r.ifc_sync[0], interface_clock_in};
      s_nxt.ifc_prev = s_r.ifc_sync[1];
      s_nxt.rdy_s1 = ready_in;
      s_nxt.rdy_s2 = s_r.rdy_s1;
      s_nxt.fd_s1 = parallel_data_bus_in;
      s_nxt.fd_s2 = s_r.fd_s1;
      // driven clock generator
      if (wrap) begin
         s_nxt.acc = 9'(acc_sum - 10'(`REF_MHZ));
         s_nxt.ifc_out = !s_r.ifc_out;
      end else begin
         s_nxt.acc = acc_sum[8:0];
      end
      // one engine step per rising interface clock edge
      if (s_r.mode == ENG_RUN && tick && !stall) begin
         s_nxt.ctl = uw[5:0];
         s_nxt.oe = uw[`UC_DRIVE] ? {wide, 1'b1} : 2'b00;
         if (uw[`UC_NEXT]) begin
            // write kinds fetch the word to drive
            if (s_r.typ == SINGLE_WRITE) begin
               s_nxt.dout = wide ? s_r.sdata : {8'h00, s_r.sdata[7:0]};
            end else if (is_fw) begin
               s_nxt.dout = ob_two ? ob_data : {8'h00, ob_data[7:0]};
            end
         end
         if (uw[`UC_SAMPLE] && s_r.typ == SINGLE_READ) begin
            s_nxt.sdata = wide ? s_r.fd_s2 : {8'h00, s_r.fd_s2[7:0]};
         end
         if (uw[`UC_AINC]) begin
            s_nxt.addr = s_r.addr + 9'h001;
         end
         s_nxt.st = nst;
         if (nst == `IDLE_STATE) begin
            // waveform over: release the bus and park the strobes
            s_nxt.mode = ENG_IDLE;
            s_nxt.oe = 2'b00;
            s_nxt.ctl = s_r.idle_ctl;
         end
      end
      if (s_r.mode == ENG_IDLE) begin
         s_nxt.ctl = s_r.idle_ctl;
      end
      // bus slave: answer each request on the next edge, drop ack after one cycle
      s_nxt.ack = req;
      s_nxt.rdat = 32'h0000_0000;
      if (req && !wb_we_in) begin
         if (uc_hit) begin
            s_nxt.rdat = ucode_r[idx[4:0]];
         end else begin
            case (idx)
               `REG_CONFIG: s_nxt.rdat = {18'h0_0000, s_r.idle_ctl, 4'h0, s_r.cfg};
               `REG_STATUS: begin
                  s_nxt.rdat[`STS_BUSY] = (s_r.mode == ENG_RUN);
                  s_nxt.rdat[`STS_STATE_LSB +: 3] = s_r.st;
                  s_nxt.rdat[`STS_OUT_CNT_LSB +: 3] = ob_count;
                  s_nxt.rdat[`STS_IN_CNT_LSB +: 3] = ib_count;
               end
               `REG_ADDRESS: s_nxt.rdat = {23'h00_0000, s_r.addr};
               `REG_DATA: s_nxt.rdat = {16'h0000, s_r.sdata};
               default: s_nxt.rdat = 32'h0000_0000; // unmapped reads as zero
            endcase
         end
      end
      if (wr && !uc_hit) begin
         case (idx)
            `REG_CONFIG: begin
               merged = ({18'h0_0000, s_r.idle_ctl, 4'h0, s_r.cfg} & ~wmask)
                        | (wb_dat_in & wmask);
               s_nxt.cfg = merged[3:0];
               s_nxt.idle_ctl = merged[`CFG_IDLE_LSB +: 6];
               if (s_r.mode == ENG_IDLE) begin
                  s_nxt.ctl = merged[`CFG_IDLE_LSB +: 6];
               end
            end
            `REG_TRIGGER: begin
               // a trigger while running is ignored
               if (s_r.mode == ENG_IDLE && wb_sel_in[0]) begin
                  s_nxt.mode = ENG_RUN;
                  s_nxt.st = 3'h0;
                  s_nxt.typ = xfer_type_e'(wb_dat_in[1:0]);
               end
            end
            `REG_ADDRESS: begin
               merged = ({23'h00_0000, s_r.addr} & ~wmask) | (wb_dat_in & wmask);
               s_nxt.addr = merged[8:0];
            end
            `REG_DATA: begin
               merged = ({16'h0000, s_r.sdata} & ~wmask) | (wb_dat_in & wmask);
               s_nxt.sdata = merged[15:0];
            end
            default: merged = 32'h0000_0000; // unmapped or strobe-only writes
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; clock enable freezes everything
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_r <= '0;
         s_r.st <= `IDLE_STATE;
      end else if (clock_enable_in) begin
         s_r <= s_nxt;
      end
   end

   // microcode RAM: loaded only while idle so a running waveform never changes
   always_ff @(posedge clock_in) begin
      if (clock_enable_in && wr && uc_hit && s_r.mode == ENG_IDLE) begin
         ucode_r[idx[4:0]] <= (ucode_r[idx[4:0]] & ~wmask) | (wb_dat_in & wmask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // host-to-peripheral packets
   packet_buffer u_out_buf (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .clock_enable_in(clock_enable_in),
      .auto_commit_in(s_r.cfg[`CFG_AUTO_COMMIT]),
      .commit_in(commit_out),
      .wr_valid_in(host_out_valid_in),
      .wr_two_in(1'b0),
      .wr_data_in({8'h00, host_out_data_in}),
      .wr_last_in(host_out_last_in),
      .wr_ready_out(host_out_ready_out),
      .rd_valid_out(ob_valid),
      .rd_data_out(ob_data),
      .rd_one_left_out(ob_one_left),
      .rd_take_in(ob_take),
      .rd_two_in(ob_two),
      .count_out(ob_count)
   );

   // peripheral-to-host packets
   packet_buffer u_in_buf (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .clock_enable_in(clock_enable_in),
      .auto_commit_in(s_r.cfg[`CFG_AUTO_COMMIT]),
      .commit_in(commit_in),
      .wr_valid_in(ib_push),
      .wr_two_in(wide),
      .wr_data_in(s_r.fd_s2),
      .wr_last_in(ib_last),
      .wr_ready_out(ib_ready),
      .rd_valid_out(host_in_valid_out),
      .rd_data_out(ib_rd_data),
      .rd_one_left_out(host_in_last_out),
      .rd_take_in(host_in_take_in),
      .rd_two_in(1'b0),
      .count_out(ib_count)
   );
   assign host_in_data_out = ib_rd_data[7:0];

   ////////////////////////////////////////////////////////////////////////////
   property p_idle_state;
      @(posedge clock_in) disable iff (!resetn_in)
         (s_r.mode == ENG_IDLE) == (s_r.st == `IDLE_STATE);
   endproperty
   a_idle_state: assert property (p_idle_state) else $error("idle mode and state 7 disagree");

   property p_idle_release;
      @(posedge clock_in) disable iff (!resetn_in)
         (s_r.mode == ENG_IDLE) |-> (parallel_data_bus_oe_out == 2'b00);
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("bus driven while idle");

   property p_idle_strobes;
      @(posedge clock_in) disable iff (!resetn_in)
         (s_r.mode == ENG_IDLE && $past(s_r.mode) == ENG_IDLE && $stable(s_r.idle_ctl))
         |-> control_strobe_out == s_r.idle_ctl;
   endproperty
   a_idle_strobes: assert property (p_idle_strobes) else $error("strobes not at idle levels");

   property p_step_on_tick;
      @(posedge clock_in) disable iff (!resetn_in)
         (s_r.mode == ENG_RUN && (!tick || !clock_enable_in)) |=> $stable(s_r.st);
   endproperty
   a_step_on_tick: assert property (p_step_on_tick) else $error("state moved off tick");

   property p_ack_next;
      @(posedge clock_in) disable iff (!resetn_in)
         (req && clock_enable_in) |=> (wb_ack_out ##1 !wb_ack_out);
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus answer not one cycle");

   property p_addr_inc;
      @(posedge clock_in) disable iff (!resetn_in)
         (s_r.mode == ENG_RUN && tick && !stall && uw[`UC_AINC] && clock_enable_in)
         |=> peripheral_address_out == $past(peripheral_address_out) + 9'h001;
   endproperty
   a_addr_inc: assert property (p_addr_inc) else $error("address did not increment");

   property p_debug_state;
      @(posedge clock_in) disable iff (!resetn_in)
         (s_r.mode == ENG_RUN && tick && !stall && clock_enable_in)
         |=> state_debug_out == $past(nst);
   endproperty
   a_debug_state: assert property (p_debug_state) else $error("debug state mismatch");
endmodule : waveform_engine

// >>> src/wfe_regs.svh
// constants for the waveform engine: register map, microcode fields, clock figures
`ifndef WFE_REGS_SVH
`define WFE_REGS_SVH
// register word indices (byte address is four times the index)
`define REG_CONFIG 6'h00
`define REG_TRIGGER 6'h01
`define REG_STATUS 6'h02
`define REG_ADDRESS 6'h03
`define REG_DATA 6'h04
`define REG_COMMIT 6'h05
// config fields
`define CFG_WIDE16 0
`define CFG_CLK_OUT 1
`define CFG_CLK_FAST 2
`define CFG_AUTO_COMMIT 3
`define CFG_IDLE_LSB 8
// status fields
`define STS_BUSY 0
`define STS_STATE_LSB 1
`define STS_OUT_CNT_LSB 4
`define STS_IN_CNT_LSB 8
// microcode: 4 descriptors of 8 words (32 bytes) each
`define UC_WORDS 32
`define UC_DRIVE 6
`define UC_SAMPLE 7
`define UC_NEXT 8
`define UC_AINC 9
`define UC_WAIT 10
`define UC_BRANCH 11
`define UC_RSEL_LSB 12
`define UC_RPOL 15
`define UC_TGT_T_LSB 16
`define UC_TGT_F_LSB 19
`define IDLE_STATE 3'h7
`define READY_ALWAYS 3'h7
// interface clock figures in MHz
`define REF_MHZ 250
`define IFC_FAST_MHZ 48
`define IFC_SLOW_MHZ 30
// packet buffers
`define SLOTS 4
`define SLOT_BYTES 64
`endif

// >>> src/wfe_pkg.sv
// types shared by the waveform engine and its packet buffer
package wfe_pkg;
   // transaction kinds, in trigger encoding order
   typedef enum logic [1:0] {SINGLE_WRITE, SINGLE_READ, FIFO_WRITE, FIFO_READ} xfer_type_e;
   // engine run mode
   typedef enum logic {ENG_IDLE, ENG_RUN} eng_mode_e;
   // whole engine state
   typedef struct packed {
      logic [1:0] ifc_sync;
      logic ifc_prev;
      logic [5:0] rdy_s1;
      logic [5:0] rdy_s2;
      logic [15:0] fd_s1;
      logic [15:0] fd_s2;
      logic [8:0] acc;
      logic ifc_out;
      eng_mode_e mode;
      logic [2:0] st;
      xfer_type_e typ;
      logic [5:0] ctl;
      logic [1:0] oe;
      logic [15:0] dout;
      logic [8:0] addr;
      logic [15:0] sdata;
      logic [3:0] cfg;
      logic [5:0] idle_ctl;
      logic ack;
      logic [31:0] rdat;
   } engine_state_s;
   // packet buffer bookkeeping
   typedef struct packed {
      logic [1:0] head;
      logic [1:0] tail;
      logic [2:0] count;
      logic pend;
      logic [6:0] wbyte;
      logic [6:0] rbyte;
      logic [3:0][6:0] len;
   } buffer_state_s;
endpackage : wfe_pkg

// >>> src/packet_buffer.sv
// four-slot packet buffer shared by both sides of one direction
`timescale 1ns/100ps
`include "wfe_regs.svh"
module packet_buffer
   import wfe_pkg::*;
(
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic clock_enable_in,
   input wire logic auto_commit_in,
   input wire logic commit_in,
   input wire logic wr_valid_in,
   input wire logic wr_two_in,
   input wire logic [15:0] wr_data_in,
   input wire logic wr_last_in,
   output logic wr_ready_out,
   output logic rd_valid_out,
   output logic [15:0] rd_data_out,
   output logic rd_one_left_out,
   input wire logic rd_take_in,
   input wire logic rd_two_in,
   output logic [2:0] count_out
);
   buffer_state_s b_r, b_nxt;
   logic [7:0] mem_r [0:`SLOTS*`SLOT_BYTES-1]; // slot memory, shared by both sides
   logic wr_go, rd_go, close, done;
   logic [6:0] nb, nr;
   logic [7:0] widx, ridx;

   ////////////////////////////////////////////////////////////////////////////
   // writer side may fill only when no packet awaits commit and a slot is free
   assign wr_ready_out = !b_r.pend && (b_r.count < 3'h4);
   assign rd_valid_out = (b_r.count != 3'h0);
   assign count_out = b_r.count;
   assign widx = {b_r.tail, b_r.wbyte[5:0]};
   assign ridx = {b_r.head, b_r.rbyte[5:0]};
   // read lane order: first byte low, next byte high
   assign rd_data_out = {mem_r[ridx + 8'h01], mem_r[ridx]};
   assign rd_one_left_out = (b_r.rbyte + 7'h01 >= b_r.len[b_r.head]);

   // next bookkeeping state
   always_comb begin
      b_nxt = b_r;
      wr_go = wr_valid_in && wr_ready_out;
      rd_go = rd_take_in && rd_valid_out;
      nb = b_r.wbyte + (wr_two_in ? 7'h02 : 7'h01);
      nr = b_r.rbyte + (rd_two_in ? 7'h02 : 7'h01);
      close = wr_go && (wr_last_in || nb == 7'(`SLOT_BYTES));
      done = rd_go && (nr >= b_r.len[b_r.head]);
      if (wr_go) begin
         b_nxt.wbyte = close ? 7'h00 : nb;
      end
      if (close) begin
         b_nxt.len[b_r.tail] = nb;
         b_nxt.pend = !auto_commit_in; // manual mode waits for software
      end
      // a closed packet moves to the reader on auto close or software commit
      if ((close && auto_commit_in) || (commit_in && b_r.pend)) begin
         b_nxt.tail = b_r.tail + 2'h1;
         b_nxt.pend = 1'b0;
      end
      if (rd_go) begin
         b_nxt.rbyte = done ? 7'h00 : nr;
      end
      if (done) begin
         b_nxt.head = b_r.head + 2'h1;
      end
      b_nxt.count = b_r.count + 3'(b_nxt.tail != b_r.tail) - 3'(done);
   end

   // state register; memory carries no reset
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         b_r <= '0;
      end else if (clock_enable_in) begin
         b_r <= b_nxt;
      end
   end

   // payload store, both lanes in one edge for 16-bit writers
   always_ff @(posedge clock_in) begin
      if (clock_enable_in && wr_go) begin
         mem_r[widx] <= wr_data_in[7:0];
         if (wr_two_in) begin
            mem_r[widx + 8'h01] <= wr_data_in[15:8];
         end
      end
   end

   property p_count_cap;
      @(posedge clock_in) disable iff (!resetn_in) b_r.count <= 3'h4;
   endproperty
   a_count_cap: assert property (p_count_cap) else $error("buffer count above four");

   property p_full_blocks;
      @(posedge clock_in) disable iff (!resetn_in) (b_r.count == 3'h4) |-> !wr_ready_out;
   endproperty
   a_full_blocks: assert property (p_full_blocks) else $error("writer accepted while full");
endmodule : packet_buffer

// >>> verification/periph_model.sv
// behavioural parallel peripheral that logs written words and answers reads late
`timescale 1ns/100ps
module periph_model (
   input wire logic clock_in,
   input wire logic clear_in,
   input wire logic [5:0] ctl_in,
   input wire logic [15:0] drive_in,
   input wire logic [1:0] oe_in,
   output logic [15:0] pin_out,
   output logic [5:0] ready_out,
   output logic [15:0] first_out,
   output logic [15:0] last_out,
   output logic [3:0] count_out
);
   logic [4:0] wait_r = 5'h00; // cycles the read strobe has stood
   logic [15:0] prev_r = 16'h0000; // last pin level, inverted while floating
   logic valid; // read data on the pins
   logic [15:0] word; // word seen, undriven high lane as zero
   ////////////////////////////////////////////////////////////
   // pins: released lanes toggle while ready is low, so a stale sample never matches
   assign valid = (wait_r == 5'h10);
   assign ready_out = {5'h00, valid};
   assign pin_out[7:0] = oe_in[0] ? drive_in[7:0] : (valid ? 8'h5A : ~prev_r[7:0]);
   assign pin_out[15:8] = oe_in[1] ? drive_in[15:8] : (valid ? 8'h3C : ~prev_r[15:8]);
   assign word = {oe_in[1] ? pin_out[15:8] : 8'h00, pin_out[7:0]};
   // ready only after strobe two held 16 cycles; a drop restarts the wait
   always_ff @(posedge clock_in) begin
      prev_r <= pin_out;
      wait_r <= ctl_in[2] ? wait_r + (valid ? 5'h00 : 5'h01) : 5'h00;
      if (clear_in) begin
         count_out <= 4'h0;
      end else if (ctl_in[1] && oe_in[0] && (count_out == 4'h0 || word != last_out)) begin
         if (count_out == 4'h0) begin
            first_out <= word;
         end
         last_out <= word;
         count_out <= count_out + 4'h1;
      end
   end
endmodule : periph_model

// >>> verification/programmable_waveform_bus_master_test.sv
// self-checking bench for the waveform engine
`timescale 1ns/100ps
module programmable_waveform_bus_master_test;
   logic clock_in = 1'b0; // 250 MHz system clock
   logic resetn_in = 1'b0; // async reset, active low
   logic cyc = 1'b0, we = 1'b0, hv = 1'b0, hl = 1'b0, clr = 1'b1;
   logic [7:0] adr = 8'h00, hd = 8'h00;
   logic [31:0] dat = 32'h00000000, rd, dout;
   logic ack, ico, icoe, hrdy, hiv, hil;
   logic [7:0] hid;
   logic [15:0] drv, pin, w_first, w_last;
   logic [1:0] oe;
   logic [5:0] ctl, rdy;
   logic [8:0] pa;
   logic [2:0] st;
   logic [3:0] wn;
   int num_errors = 0, cmp_count = 0;
   logic xclk = 1'b0; // peripheral-sourced interface clock
   logic [1:0] xdiv = 2'h0;
   // toggles every third edge: 24 ns period, inside the allowed input range
   always @(posedge clock_in) begin
      xdiv <= (xdiv == 2'h2) ? 2'h0 : xdiv + 2'h1;
      if (xdiv == 2'h2) xclk <= ~xclk;
   end
   always #2 clock_in = ~clock_in;
   ////////////////////////////////////////////////////////////
   // generated clock loops back through its own pin
   waveform_engine waveform_engine_i (.clock_in(clock_in), .resetn_in(resetn_in),
      .clock_enable_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(dout),
      .wb_ack_out(ack), .interface_clock_in(icoe ? ico : xclk), .interface_clock_out(ico),
      .interface_clock_oe_out(icoe), .peripheral_address_out(pa),
      .parallel_data_bus_in(pin), .parallel_data_bus_out(drv),
      .parallel_data_bus_oe_out(oe), .control_strobe_out(ctl), .ready_in(rdy),
      .state_debug_out(st), .host_out_valid_in(hv), .host_out_data_in(hd),
      .host_out_last_in(hl), .host_out_ready_out(hrdy), .host_in_valid_out(hiv),
      .host_in_data_out(hid), .host_in_last_out(hil), .host_in_take_in(1'b0));
   periph_model periph_model_i (.clock_in(clock_in), .clear_in(clr), .ctl_in(ctl),
      .drive_in(drv), .oe_in(oe), .pin_out(pin), .ready_out(rdy), .first_out(w_first),
      .last_out(w_last), .count_out(wn));
   ////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // a wait that ran out ends the run
   task guard(input bit ok);
      if (!ok) begin
         num_errors++;
         conclude;
      end
   endtask : guard
   // one classic cycle: hold until ack, take data at that edge, then release
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clock_in);
      cyc <= 1'b1; we <= w; adr <= a; dat <= d;
      i = 0;
      do begin @(posedge clock_in); i++; end while (ack !== 1'b1 && i < 20);
      guard(ack === 1'b1);
      rd = dout;
      cyc <= 1'b0;
   endtask : bus
   // trigger a transaction kind and poll busy until it clears
   task run(input logic [1:0] t);
      int i;
      bus(1'b1, 8'h04, {30'h0, t});
      i = 0;
      do begin bus(1'b0, 8'h08, 32'h0); i++; end while (rd[0] !== 1'b0 && i < 300);
      guard(rd[0] === 1'b0);
      check(st, 3'h7, "idle state");
      check(oe, 2'h0, "bus released");
      check(ctl, 6'h2A, "idle strobes");
   endtask : run
   ////////////////////////////////////////////////////////////
   task t_reset;
      check({st, oe, ctl}, {3'h7, 2'h0, 6'h00}, "reset outputs");
      check({hrdy, hiv}, 2'b10, "reset buffers");
      bus(1'b1, 8'h3C, 32'hFFFFFFFF);
      bus(1'b0, 8'h3C, 32'h0);
      check(rd, 32'h0, "unmapped word");
   endtask : t_reset
   // edges of the driven clock in 1250 cycles (5 us): 240 fast, 150 slow
   task t_clock;
      int n, e;
      logic p;
      for (int f = 0; f < 2; f++) begin
         bus(1'b1, 8'h00, {18'h0, 6'h2A, 5'h0, f[0], 2'b10});
         n = 0; p = ico; e = f ? 240 : 150;
         repeat (1250) begin @(posedge clock_in); n += (ico && !p); p = ico; end
         check(icoe, 1'b1, "clock drive");
         check((n >= e - 1 && n <= e + 1) ? e : n, e, "clock edges");
         check(ctl, 6'h2A, "idle strobes");
      end
   endtask : t_clock
   // single write, 8-bit, address wraps from the top value
   task t_write;
      bus(1'b1, 8'h00, 32'h2A06);
      bus(1'b1, 8'h80, 32'h87343);
      bus(1'b1, 8'h84, 32'h387043);
      bus(1'b1, 8'h0C, 32'h1FF);
      bus(1'b1, 8'h10, 32'hA5);
      clr <= 1'b0;
      run(2'd0);
      check({wn, w_first}, {4'h1, 16'h00A5}, "written word");
      check(pa, 9'h000, "address increment");
   endtask : t_write
   // single read on the peripheral's clock: strobe first, then wait on ready zero
   task t_read;
      bus(1'b1, 8'h00, 32'h2A00);
      check(icoe, 1'b0, "clock input mode");
      bus(1'b1, 8'hA0, 32'h87004);
      bus(1'b1, 8'hA4, 32'h380484);
      run(2'd1);
      bus(1'b0, 8'h10, 32'h0);
      check(rd[7:0], 8'h5A, "read byte");
   endtask : t_read
   // fifo write, 16-bit: host packet of four bytes crosses without software
   task t_fifo;
      int i;
      clr <= 1'b1;
      bus(1'b1, 8'h00, 32'h2A0F);
      bus(1'b1, 8'hC0, 32'h87142);
      bus(1'b1, 8'hC4, 32'h107142);
      bus(1'b1, 8'hC8, 32'h387042);
      for (int k = 0; k < 4; k++) begin
         hv <= 1'b1; hd <= 8'(8'h11 * (k + 1)); hl <= (k == 3); clr <= 1'b0;
         i = 0;
         do begin @(posedge clock_in); i++; end while (hrdy !== 1'b1 && i < 50);
         guard(hrdy === 1'b1);
      end
      hv <= 1'b0;
      bus(1'b0, 8'h08, 32'h0);
      check(rd[6:4], 3'h1, "queued packets");
      run(2'd2);
      check({wn, w_first, w_last}, {4'h2, 16'h2211, 16'h4433}, "lane order");
      bus(1'b0, 8'h08, 32'h0);
      check(rd[6:4], 3'h0, "drained packets");
   endtask : t_fifo
   // fifo read, 16-bit, manual commit: the packet waits for software first
   task t_drain;
      bus(1'b1, 8'h00, 32'h2A07);
      bus(1'b1, 8'hE0, 32'h87004);
      bus(1'b1, 8'hE4, 32'h100484);
      bus(1'b1, 8'hE8, 32'h387084);
      run(2'd3);
      bus(1'b0, 8'h08, 32'h0);
      check({rd[10:8], hiv}, {3'h0, 1'b0}, "uncommitted packet");
      bus(1'b1, 8'h14, 32'h2);
      check({hiv, hid, hil}, {1'b1, 8'h5A, 1'b0}, "committed packet");
   endtask : t_drain
   initial begin
      repeat (2) @(posedge clock_in);
      resetn_in <= 1'b1;
      @(posedge clock_in);
      t_reset;
      t_clock;
      t_write;
      t_read;
      t_fifo;
      t_drain;
      conclude;
   end
endmodule : programmable_waveform_bus_master_test
